// [ubh_params.svh]
/*
  Constants of the endpoint bank and handshake block: register
  offsets, control/status bit positions, bank geometry.
  Assumes inclusion before the ubh package and the design modules.
*/
`ifndef UBH_PARAMS_SVH
`define UBH_PARAMS_SVH

`define UBH_ADDR_W      8
`define UBH_ADDR_CSR    8'h00
`define UBH_ADDR_FDR    8'h04
`define UBH_DEPTH       7'h40
`define UBH_IDX_W       6
`define UBH_CNT_W       7
`define UBH_MEM_W       7
`define UBH_B_TX_COMPLETE_FLAG    0
`define UBH_B_RX0       1
`define UBH_B_STSENT    3
`define UBH_B_TXRDY     4
`define UBH_B_FSTALL    5
`define UBH_B_RX1       6
`define UBH_B_DUAL      7
`define UBH_B_DIRIN     8
`define UBH_F_CNT_LO    16
`define UBH_F_CNT_HI    22
`define UBH_CNT_ONE     7'h01
`define UBH_RST_WORD    32'h0000_0000

`endif

// [ubh_pkg.sv]
/*
  Types of the endpoint bank and handshake block.
  Assumes ubh_params.svh is reachable by bare name.
*/
`include "ubh_params.svh"

package ubh_pkg;

  typedef enum logic [1:0] {UBH_HS_ACK, UBH_HS_NAK, UBH_HS_STALL} ubh_hs_code_t;

  typedef struct packed {
    logic         valid;
    ubh_hs_code_t code;
  } ubh_hs_t;

  typedef struct packed {
    logic valid;
    logic is_in;
  } ubh_tok_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } ubh_rx_byte_t;

  typedef struct packed {
    logic       valid;
    logic       eop;
    logic [7:0] data;
  } ubh_tx_byte_t;

  typedef enum logic [2:0] {ST_IDLE, ST_OUT_RECV, ST_OUT_DROP, ST_IN_SEND, ST_IN_WAIT} ubh_fsm_t;

  typedef struct packed {
    ubh_fsm_t                   st;
    logic                       dual;
    logic                       dir_in;
    logic                       force_stall;
    logic                       stall_sent;
    logic                       tx_comp;
    logic [1:0]                 tx_rdy;
    logic [1:0][`UBH_CNT_W-1:0] tx_len;
    logic                       tx_fill;
    logic                       tx_send;
    logic [`UBH_CNT_W-1:0]      tx_wcnt;
    logic [`UBH_CNT_W-1:0]      send_idx;
    logic [1:0]                 rx_full;
    logic [1:0][`UBH_CNT_W-1:0] rx_len;
    logic                       rx_fill;
    logic                       rx_rd;
    logic [`UBH_CNT_W-1:0]      rx_rptr;
    logic [`UBH_CNT_W-1:0]      rx_wcnt;
    logic                       drop_stall;
    logic [31:0]                rdata;
    ubh_tx_byte_t               txo;
    logic                       irq;
  } ubh_st_t;

endpackage : ubh_pkg

// [ubh_bank_store.sv]
/*
  Two endpoint banks of byte storage in flip-flops, one write port,
  two combinational read ports.
  Assumes callers keep indices below the bank depth.
*/
`timescale 1ns/1ps
`include "ubh_params.svh"

module ubh_bank_store
  import ubh_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  we,
  input  wire logic                  wbank,
  input  wire logic [`UBH_IDX_W-1:0] widx,
  input  wire logic [7:0]            wdata,
  input  wire logic                  abank,
  input  wire logic [`UBH_IDX_W-1:0] aidx,
  output logic      [7:0]            adata,
  input  wire logic                  bbank,
  input  wire logic [`UBH_IDX_W-1:0] bidx,
  output logic      [7:0]            bdata
);

  typedef struct packed {
    logic [127:0][7:0] mem;
  } ubh_store_t;

  ubh_store_t s;
  ubh_store_t next_s;

  function automatic logic [`UBH_MEM_W-1:0] ubh_loc(input logic b,
                                                   input logic [`UBH_IDX_W-1:0] i);
    ubh_loc = {b, i};
  endfunction : ubh_loc

  always_comb
  begin
    next_s = s;
    if (we)
      next_s.mem[ubh_loc(wbank, widx)] = wdata;
  end

  assign adata = s.mem[ubh_loc(abank, aidx)];
  assign bdata = s.mem[ubh_loc(bbank, bidx)];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '0;
    else
      s <= next_s;
  end

endmodule : ubh_bank_store

// [ubh_hs_gen.sv]
/*
  Handshake output stage: registers a one-cycle handshake request.
  Assumes requests come from logic on the same clock.
*/
`timescale 1ns/1ps

module ubh_hs_gen
  import ubh_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    arst_n,
  input  wire ubh_hs_t req,
  output ubh_hs_t      hs
);

  ubh_hs_t s;
  ubh_hs_t next_s;

  always_comb
  begin
    next_s = req;
  end

  assign hs = s;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '0;
    else
      s <= next_s;
  end

endmodule : ubh_hs_gen

// [ubh_endpoint.sv]
/*
  One full-speed endpoint: ping-pong and single-bank data IN and OUT
  transactions, stall handshakes, control/status and FIFO data access.
  Assumes a serial engine on the same clock that delivers decoded
  tokens, received bytes and host ACKs, and sends the handshakes and
  bytes given here. Register port: one-cycle strobes, read data the
  cycle after the read strobe.
*/
// Functional notes
// - ping-pong endpoint: two banks, engine and processor
// - tx-complete set on release, interrupt pending meanwhile
// - tx-complete only after host ACK
// - no ready bank: IN token gets NAK
// - single bank busy: NAK, else store and ACK
// - bank zero stored: flag set, interrupt pending
// - byte count of received bank readable
// - payload bytes read out in order
// - clearing bank-zero flag frees single bank
// - ping-pong: second packet goes to bank one
// - bank one stored: flag set, interrupt pending
// - cleared bank zero takes next packet, alternating
// - force-stall: transactions answered with STALL
// - STALL sent sets flag, firmware clears it
`timescale 1ns/1ps
`include "ubh_params.svh"

module ubh_endpoint
  import ubh_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic [`UBH_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire ubh_tok_t              tok,
  input  wire ubh_rx_byte_t          rx_byte,
  input  wire logic                  host_ack,
  output ubh_tx_byte_t               tx_byte,
  output ubh_hs_t                    hs_out,
  output logic                       ep_irq
);

  ubh_st_t                s;
  ubh_st_t                next_s;
  ubh_hs_t                hs_req;
  logic                   mem_we;
  logic                   mem_wbank;
  logic [`UBH_IDX_W-1:0]  mem_widx;
  logic [7:0]             mem_wdata;
  logic [7:0]             tx_rdata;
  logic [7:0]             fw_rdata;
  logic                   rd_bank;

  // oldest full bank; with both full the alternation pointer decides
  function automatic logic ubh_rd_sel(input logic dual, input logic [1:0] full,
                                      input logic ptr);
    if (!dual)
      ubh_rd_sel = 1'b0;
    else if (full == 2'b10)
      ubh_rd_sel = 1'b1;
    else if (full == 2'b01)
      ubh_rd_sel = 1'b0;
    else
      ubh_rd_sel = ptr;
  endfunction : ubh_rd_sel

  function automatic logic ubh_flip(input logic dual, input logic b);
    ubh_flip = dual ? ~b : 1'b0;
  endfunction : ubh_flip

  assign rd_bank = ubh_rd_sel(s.dual, s.rx_full, s.rx_rd);

  ubh_bank_store u_store (
    .clk    (clk),
    .arst_n (arst_n),
    .we     (mem_we),
    .wbank  (mem_wbank),
    .widx   (mem_widx),
    .wdata  (mem_wdata),
    .abank  (s.tx_send),
    .aidx   (s.send_idx[`UBH_IDX_W-1:0]),
    .adata  (tx_rdata),
    .bbank  (rd_bank),
    .bidx   (s.rx_rptr[`UBH_IDX_W-1:0]),
    .bdata  (fw_rdata)
  );

  ubh_hs_gen u_hs (
    .clk    (clk),
    .arst_n (arst_n),
    .req    (hs_req),
    .hs     (hs_out)
  );

  always_comb
  begin
    next_s    = s;
    hs_req    = '0;
    mem_we    = 1'b0;
    mem_wbank = 1'b0;
    mem_widx  = '0;
    mem_wdata = '0;
    next_s.txo   = '0;
    next_s.rdata = `UBH_RST_WORD;

    // software side first, so that engine events below win a clash
    if (reg_wr && reg_addr == `UBH_ADDR_CSR)
    begin
      next_s.force_stall = reg_wdata[`UBH_B_FSTALL];
      next_s.dual        = reg_wdata[`UBH_B_DUAL];
      next_s.dir_in      = reg_wdata[`UBH_B_DIRIN];
      // leaving ping-pong mode must not strand a pointer on bank one
      next_s.rx_fill     = s.rx_fill & reg_wdata[`UBH_B_DUAL];
      next_s.tx_fill     = s.tx_fill & reg_wdata[`UBH_B_DUAL];
      next_s.tx_send     = s.tx_send & reg_wdata[`UBH_B_DUAL];
      if (!reg_wdata[`UBH_B_TX_COMPLETE_FLAG])
        next_s.tx_comp = 1'b0;
      if (!reg_wdata[`UBH_B_STSENT])
        next_s.stall_sent = 1'b0;
      if (!reg_wdata[`UBH_B_RX0] && s.rx_full[0])
      begin
        next_s.rx_full[0] = 1'b0;
        next_s.rx_rd      = s.dual;
        next_s.rx_rptr    = '0;
      end
      if (!reg_wdata[`UBH_B_RX1] && s.rx_full[1])
      begin
        next_s.rx_full[1] = 1'b0;
        next_s.rx_rd      = 1'b0;
        next_s.rx_rptr    = '0;
      end
      // a ready bank keeps its flag and length; FDR writes still land in it
      if (reg_wdata[`UBH_B_TXRDY] && !s.tx_rdy[s.tx_fill])
      begin
        next_s.tx_rdy[s.tx_fill] = 1'b1;
        next_s.tx_len[s.tx_fill] = s.tx_wcnt;
        next_s.tx_wcnt           = '0;
        next_s.tx_fill           = ubh_flip(s.dual, s.tx_fill);
      end
    end

    // bytes beyond a full bank are dropped, not wrapped
    if (reg_wr && reg_addr == `UBH_ADDR_FDR && s.dir_in && s.tx_wcnt < `UBH_DEPTH)
    begin
      mem_we         = 1'b1;
      mem_wbank      = s.tx_fill;
      mem_widx       = s.tx_wcnt[`UBH_IDX_W-1:0];
      mem_wdata      = reg_wdata[7:0];
      next_s.tx_wcnt = s.tx_wcnt + `UBH_CNT_ONE;
    end

    if (reg_rd)
    begin
      unique case (reg_addr)
        `UBH_ADDR_CSR:
        begin
          next_s.rdata[`UBH_B_TX_COMPLETE_FLAG] = s.tx_comp;
          next_s.rdata[`UBH_B_RX0]    = s.rx_full[0];
          next_s.rdata[`UBH_B_STSENT] = s.stall_sent;
          next_s.rdata[`UBH_B_TXRDY]  = |s.tx_rdy;
          next_s.rdata[`UBH_B_FSTALL] = s.force_stall;
          next_s.rdata[`UBH_B_RX1]    = s.rx_full[1];
          next_s.rdata[`UBH_B_DUAL]   = s.dual;
          next_s.rdata[`UBH_B_DIRIN]  = s.dir_in;
          next_s.rdata[`UBH_F_CNT_HI:`UBH_F_CNT_LO] =
            s.rx_full[rd_bank] ? s.rx_len[rd_bank] : '0;
        end
        `UBH_ADDR_FDR:
        begin
          next_s.rdata[7:0] = fw_rdata;
          if (s.rx_rptr < s.rx_len[rd_bank])
            next_s.rx_rptr = s.rx_rptr + `UBH_CNT_ONE;
        end
        default:
          next_s.rdata = `UBH_RST_WORD;
      endcase
    end

    unique case (s.st)
      ST_IDLE:
      begin
        if (tok.valid && tok.is_in)
        begin
          if (s.force_stall)
          begin
            hs_req            = '{valid: 1'b1, code: UBH_HS_STALL};
            next_s.stall_sent = 1'b1;
          end
          else if (s.tx_rdy[s.tx_send])
          begin
            next_s.send_idx = '0;
            next_s.st       = ST_IN_SEND;
          end
          else
            hs_req = '{valid: 1'b1, code: UBH_HS_NAK};
        end
        else if (tok.valid)
        begin
          next_s.rx_wcnt    = '0;
          next_s.drop_stall = s.force_stall;
          // host keeps retrying while the target bank is still owned
          if (s.force_stall || s.rx_full[s.rx_fill])
            next_s.st = ST_OUT_DROP;
          else
            next_s.st = ST_OUT_RECV;
        end
      end
      ST_OUT_RECV:
      begin
        if (rx_byte.valid)
        begin
          if (s.rx_wcnt < `UBH_DEPTH)
          begin
            mem_we         = 1'b1;
            mem_wbank      = s.rx_fill;
            mem_widx       = s.rx_wcnt[`UBH_IDX_W-1:0];
            mem_wdata      = rx_byte.data;
            next_s.rx_wcnt = s.rx_wcnt + `UBH_CNT_ONE;
          end
          if (rx_byte.last)
          begin
            next_s.rx_full[s.rx_fill] = 1'b1;
            next_s.rx_len[s.rx_fill]  = next_s.rx_wcnt;
            next_s.rx_fill = ubh_flip(s.dual, s.rx_fill);
            hs_req    = '{valid: 1'b1, code: UBH_HS_ACK};
            next_s.st = ST_IDLE;
          end
        end
      end
      ST_OUT_DROP:
      begin
        if (rx_byte.valid && rx_byte.last)
        begin
          if (s.drop_stall)
          begin
            hs_req            = '{valid: 1'b1, code: UBH_HS_STALL};
            next_s.stall_sent = 1'b1;
          end
          else
            hs_req = '{valid: 1'b1, code: UBH_HS_NAK};
          next_s.st = ST_IDLE;
        end
      end
      ST_IN_SEND:
      begin
        if (s.send_idx < s.tx_len[s.tx_send])
        begin
          next_s.txo      = '{valid: 1'b1, eop: 1'b0, data: tx_rdata};
          next_s.send_idx = s.send_idx + `UBH_CNT_ONE;
        end
        else
        begin
          next_s.txo = '{valid: 1'b0, eop: 1'b1, data: 8'h00};
          next_s.st  = ST_IN_WAIT;
        end
      end
      ST_IN_WAIT:
      begin
        // a lost ACK shows as a repeated IN token: send the same bank again
        if (host_ack)
        begin
          next_s.tx_rdy[s.tx_send] = 1'b0;
          next_s.tx_comp = 1'b1;
          next_s.tx_send = ubh_flip(s.dual, s.tx_send);
          next_s.st      = ST_IDLE;
        end
        else if (tok.valid && tok.is_in)
        begin
          next_s.send_idx = '0;
          next_s.st       = ST_IN_SEND;
        end
        else if (tok.valid)
          next_s.st = ST_IDLE;
      end
    endcase

    next_s.irq = next_s.tx_comp | (|next_s.rx_full) | next_s.stall_sent;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign reg_rdata = s.rdata;
  assign tx_byte   = s.txo;
  assign ep_irq    = s.irq;

  ack_has_data_a: assert property (@(posedge clk) disable iff (!arst_n)
    (hs_out.valid && hs_out.code == UBH_HS_ACK) |-> (s.rx_full != 2'b00))
    else $error("ACK sent with no bank holding data");
  out_busy_nak_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s.st == ST_IDLE && tok.valid && !tok.is_in && !s.force_stall
     && s.rx_full[s.rx_fill]) |=> (s.st == ST_OUT_DROP))
    else $error("OUT into an owned bank not refused");
  comp_after_ack_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s.st == ST_IN_WAIT && host_ack) |=> (s.tx_comp && s.irq))
    else $error("tx complete missing after host ACK");
  comp_needs_ack_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(s.tx_comp) |-> $past(host_ack))
    else $error("tx complete set without host ACK");
  in_empty_nak_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s.st == ST_IDLE && tok.valid && tok.is_in && !s.force_stall
     && !s.tx_rdy[s.tx_send]) |=> (hs_out.valid && hs_out.code == UBH_HS_NAK))
    else $error("IN with no ready bank not NAKed");
  stall_answer_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s.st == ST_IDLE && tok.valid && tok.is_in && s.force_stall)
    |=> (hs_out.valid && hs_out.code == UBH_HS_STALL && s.stall_sent))
    else $error("forced stall not answered with STALL");
  irq_pending_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s.tx_comp || s.rx_full != 2'b00 || s.stall_sent) |-> ep_irq)
    else $error("pending flag without endpoint interrupt");
  fifo_order_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == `UBH_ADDR_FDR && s.rx_rptr < s.rx_len[rd_bank])
    |=> (s.rx_rptr == $past(s.rx_rptr) + `UBH_CNT_ONE))
    else $error("FIFO read pointer did not advance by one");
  bank_alternate_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s.dual && s.st == ST_IN_WAIT && host_ack) |=> (s.tx_send != $past(s.tx_send)))
    else $error("IN bank order did not alternate");
  bank_one_dual_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(s.rx_full[1]) |-> (s.dual && $past(s.rx_fill)))
    else $error("bank one filled outside ping-pong order");

endmodule : ubh_endpoint

// [ubh_host_model.sv]
/*
  Host on the far side of the endpoint: sends OUT and IN tokens,
  OUT payload bytes and the ACK for received IN data.
  Assumes the endpoint's link timing: handshake within a few cycles.
*/
`timescale 1ns/1ps

module ubh_host_model
  import ubh_pkg::*;
(
  input  wire logic         clk,
  input  wire ubh_tx_byte_t tx_byte,
  input  wire ubh_hs_t      hs_out,
  output ubh_tok_t          tok,
  output ubh_rx_byte_t      rx_byte,
  output logic              host_ack
);
  logic [7:0] got [$];

  initial
  begin
    tok      = '0;
    rx_byte  = '0;
    host_ack = 1'b0;
  end

  // out packet of n bytes counting up from base; n >= 1
  task automatic out_pkt(input logic [7:0] base, input int n, output ubh_hs_code_t code);
    int i;
    code = ubh_hs_code_t'(2'h3);
    @(posedge clk);
    tok <= '{valid: 1'b1, is_in: 1'b0};
    for (i = 0; i < n; i++)
    begin
      @(posedge clk);
      tok     <= '0;
      rx_byte <= '{valid: 1'b1, last: (i == n - 1), data: 8'(base + i)};
    end
    @(posedge clk);
    // released line shows the inverse so a stale byte cannot pass
    rx_byte <= '{valid: 1'b0, last: 1'b0, data: ~8'(base + n - 1)};
    for (i = 0; i < 6; i++)
    begin
      @(posedge clk);
      if (hs_out.valid)
      begin
        code = hs_out.code;
        break;
      end
    end
  endtask : out_pkt

  // in token; code ACK means data arrived, got holds the payload
  task automatic in_pkt(input logic ack, output ubh_hs_code_t code);
    int i;
    got.delete();
    code = ubh_hs_code_t'(2'h3);
    @(posedge clk);
    tok <= '{valid: 1'b1, is_in: 1'b1};
    @(posedge clk);
    tok <= '0;
    for (i = 0; i < 200; i++)
    begin
      @(posedge clk);
      if (hs_out.valid)
      begin
        code = hs_out.code;
        break;
      end
      if (tx_byte.eop)
      begin
        code = UBH_HS_ACK;
        break;
      end
      if (tx_byte.valid)
        got.push_back(tx_byte.data);
    end
    if (ack && code == UBH_HS_ACK)
    begin
      host_ack <= 1'b1;
      @(posedge clk);
      host_ack <= 1'b0;
    end
  endtask : in_pkt
endmodule : ubh_host_model

// [tb.sv]
/*
  Self-checking bench of the endpoint: register tasks and host calls.
  Assumes the design files and the host model are compiled first.
*/
`timescale 1ns/1ps
`include "ubh_params.svh"

module tb
  import ubh_pkg::*;
;
  logic                    clk;
  logic                    arst_n;
  logic [`UBH_ADDR_W-1:0]  reg_addr;
  logic [31:0]             reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [31:0]             reg_rdata;
  ubh_tok_t                tok;
  ubh_rx_byte_t            rx_byte;
  logic                    host_ack;
  ubh_tx_byte_t            tx_byte;
  ubh_hs_t                 hs_out;
  logic                    ep_irq;
  int                      miscompares;
  int                      compares;
  ubh_hs_code_t            hc;

  ubh_endpoint uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tok(tok), .rx_byte(rx_byte),
    .host_ack(host_ack), .tx_byte(tx_byte), .hs_out(hs_out), .ep_irq(ep_irq));

  ubh_host_model host (.clk(clk), .tx_byte(tx_byte), .hs_out(hs_out), .tok(tok),
    .rx_byte(rx_byte), .host_ack(host_ack));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_hs(input string what, input ubh_hs_code_t exp, input ubh_hs_code_t got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_hs

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(what, exp, v);
  endtask : rchk

  // interrupt is a registered level, so let the flag update land first
  task automatic ichk(input logic exp);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", {31'h0, exp}, {31'h0, ep_irq});
  endtask : ichk

  task automatic fifo(input logic [7:0] base, input int n);
    logic [31:0] v;
    for (int i = 0; i < n; i++)
    begin
      rd(8'h04, v);
      chk("fifo", {24'h0, 8'(base + i)}, {24'h0, v[7:0]});
    end
  endtask : fifo

  task automatic fill(input logic [7:0] base, input int n);
    for (int i = 0; i < n; i++)
      wr(8'h04, {24'h0, 8'(base + i)});
  endtask : fill

  task automatic pay(input logic [7:0] base, input int n);
    chk("in count", 32'(n), 32'(host.got.size()));
    for (int i = 0; i < host.got.size(); i++)
      chk("in byte", {24'h0, 8'(base + i)}, {24'h0, host.got[i]});
  endtask : pay

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial
  begin
    miscompares = 0;
    compares    = 0;
    arst_n      = 1'b0;
    reg_addr    = '0;
    reg_wdata   = '0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rchk("csr", 8'h00, 32'h0000_0000);
    rchk("unmapped", 8'h08, 32'h0000_0000);
    $display("test reset done");
    // single bank out: flag bits written as one keep them
    wr(8'h00, 32'h0000_004B);
    host.out_pkt(8'hA0, 3, hc);
    chk_hs("out", UBH_HS_ACK, hc);
    rchk("csr", 8'h00, 32'h0003_0002);
    ichk(1'b1);
    host.out_pkt(8'hB0, 2, hc);
    chk_hs("out busy", UBH_HS_NAK, hc);
    rchk("csr", 8'h00, 32'h0003_0002);
    fifo(8'hA0, 3);
    wr(8'h00, 32'h0000_0049);
    ichk(1'b0);
    host.out_pkt(8'hC0, 1, hc);
    chk_hs("out freed", UBH_HS_ACK, hc);
    fifo(8'hC0, 1);
    wr(8'h00, 32'h0000_0049);
    $display("test single_out done");
    // ping-pong out, both banks filled back to back
    wr(8'h00, 32'h0000_00CB);
    host.out_pkt(8'h10, 2, hc);
    chk_hs("out b0", UBH_HS_ACK, hc);
    host.out_pkt(8'h20, 4, hc);
    chk_hs("out b1", UBH_HS_ACK, hc);
    rchk("csr", 8'h00, 32'h0002_00C2);
    host.out_pkt(8'h30, 1, hc);
    chk_hs("out full", UBH_HS_NAK, hc);
    fifo(8'h10, 2);
    wr(8'h00, 32'h0000_00C9);
    rchk("csr", 8'h00, 32'h0004_00C0);
    ichk(1'b1);
    host.out_pkt(8'h40, 1, hc);
    chk_hs("out b0 again", UBH_HS_ACK, hc);
    fifo(8'h20, 4);
    wr(8'h00, 32'h0000_008B);
    rchk("csr", 8'h00, 32'h0001_0082);
    fifo(8'h40, 1);
    wr(8'h00, 32'h0000_00C9);
    ichk(1'b0);
    $display("test pingpong_out done");
    // ping-pong in
    wr(8'h00, 32'h0000_01CB);
    host.in_pkt(1'b1, hc);
    chk_hs("in empty", UBH_HS_NAK, hc);
    fill(8'h50, 2);
    wr(8'h00, 32'h0000_01DB);
    fill(8'h60, 3);
    host.in_pkt(1'b0, hc);
    rchk("csr", 8'h00, 32'h0000_0190);
    host.in_pkt(1'b1, hc);
    chk_hs("in b0", UBH_HS_ACK, hc);
    pay(8'h50, 2);
    rchk("csr", 8'h00, 32'h0000_0181);
    ichk(1'b1);
    wr(8'h00, 32'h0000_01DA);
    host.in_pkt(1'b1, hc);
    chk_hs("in b1", UBH_HS_ACK, hc);
    pay(8'h60, 3);
    wr(8'h00, 32'h0000_01CA);
    host.in_pkt(1'b1, hc);
    chk_hs("in drained", UBH_HS_NAK, hc);
    ichk(1'b0);
    $display("test pingpong_in done");
    // forced stall
    wr(8'h00, 32'h0000_002B);
    host.out_pkt(8'h70, 1, hc);
    chk_hs("stall out", UBH_HS_STALL, hc);
    rchk("csr", 8'h00, 32'h0000_0028);
    ichk(1'b1);
    host.in_pkt(1'b1, hc);
    chk_hs("stall in", UBH_HS_STALL, hc);
    wr(8'h00, 32'h0000_0043);
    rchk("csr", 8'h00, 32'h0000_0000);
    ichk(1'b0);
    $display("test stall done");
    conclude();
  end
endmodule : tb
